// File: rtl/gpa_pkg.sv
// Package for general-purpose port A: register map, reset values, carriers.
// Assumes APB with 32-bit data; registers occupy one aligned word each.
package gpa_pkg;

  // Register byte addresses
  localparam logic [7:0] GPA_ADDR_LEVEL = 8'h00;
  localparam logic [7:0] GPA_ADDR_DIR   = 8'h04;
  localparam logic [7:0] GPA_ADDR_ANSEL = 8'h08;
  localparam logic [7:0] GPA_ADDR_PULL  = 8'h0c;
  localparam logic [7:0] GPA_ADDR_OPT   = 8'h10;
  localparam logic [7:0] GPA_ADDR_IOC   = 8'h14;
  localparam logic [7:0] GPA_ADDR_IST   = 8'h18;
  localparam logic [7:0] GPA_ADDR_IMSK  = 8'h1c;

  // Implemented bit masks
  localparam logic [7:0] GPA_PIN_MASK   = 8'hef;
  localparam logic [7:0] GPA_DIR_WMASK  = 8'hcf;
  localparam logic [7:0] GPA_ANSEL_MASK = 8'h0f;
  localparam logic [7:0] GPA_PULL_MASK  = 8'h2f;
  localparam logic [7:0] GPA_IOC_MASK   = 8'hf7;

  // Field positions
  localparam int GPA_INPUT_ONLY_BIT = 5;
  localparam int GPA_OPEN_DRAIN_BIT = 7;
  localparam int GPA_OPT_PU_DIS_BIT = 0;
  localparam int GPA_FUSE_RESET_BIT = 5;

  // Reset values
  localparam logic [7:0] GPA_DIR_RST   = 8'hef;
  localparam logic [7:0] GPA_ANSEL_RST = 8'h0f;
  localparam logic [7:0] GPA_PULL_RST  = 8'h2f;
  localparam logic [7:0] GPA_LATCH_RST = 8'h00;
  localparam logic [7:0] GPA_ZERO      = 8'h00;
  localparam logic       GPA_PU_DIS_RST = 1'b1;

  // Alternate function output request from one peripheral
  typedef struct packed {
    logic en;
    logic val;
  } gpa_alt_s;

  // Peripheral output requests, in rising priority per pin
  typedef struct packed {
    gpa_alt_s dbg0;
    gpa_alt_s clko1;
    gpa_alt_s tmr2;
    gpa_alt_s int2;
    gpa_alt_s rst5;
    gpa_alt_s ten5;
    gpa_alt_s ccd6;
    gpa_alt_s pgd6;
    gpa_alt_s scl7;
  } gpa_alts_s;

  // Pin drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpa_pins_s;

  // Module state
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] ansel;
    logic [7:0] pull_en;
    logic       pu_dis;
    logic [7:0] ioc_en;
    logic [7:0] ist;
    logic [7:0] imsk;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
    logic       irq;
    gpa_pins_s  pins;
  } gpa_state_s;

endpackage

// File: rtl/gpa_port.sv
// General-purpose port A: direction, latch, analog select, pull-ups,
// change interrupts, output priority, APB register slave.
// Assumes pad logic resolves PIN_OUT/PIN_OE/PIN_PULL to the pad wires.
//
// Operation
// - Eight-bit port, five push-pull, one open-drain I/O, one input; bit 4 zero.
// - Direction bit one disables driver (input); zero enables driver.
// - Pin 5 input only; its direction bit always reads one.
// - Data read returns pin levels; write updates latch only, read-modify-write.
// - Analog-selected pins read zero; digital input buffer disabled.
// - Analog select does not stop output driving.
// - Digital output pin reads back the actual pin state.
// - Analog select bits reset to one.
// - Per-pin change interrupt enables, bits 7:4 and 2:0, off at reset.
// - Pull-ups only on pins 3:0 and 5; pins 3:0 each with own enable.
// - Pull-up removed for outputs, alternates, and global disable set at reset.
// - Pin 5 pull-up follows the fuse reset-pin selection only.
// - Pin 7 open drain: only pulls low.
// - Highest-priority enabled source controls the pin, also in analog mode.
// - Fixed per-pin priority from latch up to peripheral functions.
// - Enabled peripheral takes the pin away from general-purpose I/O.
// - Pull-up needs global enable, input, own bit set, not analog.
// - Analog select also disables pull-up and change interrupt.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps

module gpa_port (
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic [7:0]        PADDR,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [7:0]        PIN_IN,
  output logic [7:0]             PIN_OUT,
  output logic [7:0]             PIN_OE,
  output logic [7:0]             PIN_PULL,
  input  wire logic [13:0]       FUSE_WORD,
  input  wire gpa_pkg::gpa_alts_s ALT_OUT,
  output logic                   IRQ
);

  gpa_pkg::gpa_state_s st_reg;
  gpa_pkg::gpa_state_s st_next;

  // Drive decision per pin, combinational helpers
  logic [7:0] drv_val;
  logic [7:0] alt_own;
  logic [7:0] dir_eff;
  logic [7:0] rd_level;
  logic [7:0] pull_w;
  logic [7:0] chg;
  logic [7:0] wmask;
  logic       wr;
  logic       rd;
  logic       known;

  // Output priority: later sources override earlier ones
  always_comb begin
    drv_val = st_reg.latch;
    alt_own = 8'h00;
    if (ALT_OUT.dbg0.en) begin
      drv_val[0] = ALT_OUT.dbg0.val;
      alt_own[0] = 1'b1;
    end
    if (ALT_OUT.clko1.en) begin
      drv_val[1] = ALT_OUT.clko1.val;
      alt_own[1] = 1'b1;
    end
    if (ALT_OUT.tmr2.en) begin
      drv_val[2] = ALT_OUT.tmr2.val;
      alt_own[2] = 1'b1;
    end
    if (ALT_OUT.int2.en) begin
      drv_val[2] = ALT_OUT.int2.val;
      alt_own[2] = 1'b1;
    end
    if (ALT_OUT.rst5.en) begin
      drv_val[5] = ALT_OUT.rst5.val;
      alt_own[5] = 1'b1;
    end
    if (ALT_OUT.ten5.en) begin
      drv_val[5] = ALT_OUT.ten5.val;
      alt_own[5] = 1'b1;
    end
    if (ALT_OUT.ccd6.en) begin
      drv_val[6] = ALT_OUT.ccd6.val;
      alt_own[6] = 1'b1;
    end
    if (ALT_OUT.pgd6.en) begin
      drv_val[6] = ALT_OUT.pgd6.val;
      alt_own[6] = 1'b1;
    end
    if (ALT_OUT.scl7.en) begin
      drv_val[7] = ALT_OUT.scl7.val;
      alt_own[7] = 1'b1;
    end
  end

  // Effective direction with fixed bits forced
  assign dir_eff = (st_reg.dir | ~gpa_pkg::GPA_PIN_MASK)
                 | (8'h01 << gpa_pkg::GPA_INPUT_ONLY_BIT);

  // Digital read path: analog pins read zero, bit 4 absent
  assign rd_level = st_reg.sync2 & ~st_reg.ansel & gpa_pkg::GPA_PIN_MASK;

  // Pull-up qualification per pin
  always_comb begin
    pull_w = st_reg.pull_en & gpa_pkg::GPA_PULL_MASK & dir_eff
           & ~st_reg.ansel & ~alt_own;
    if (st_reg.pu_dis) begin
      pull_w = 8'h00;
    end
    pull_w[gpa_pkg::GPA_INPUT_ONLY_BIT] =
      FUSE_WORD[gpa_pkg::GPA_FUSE_RESET_BIT];
  end

  // Level changes on enabled, digital pins
  assign chg = (rd_level ^ st_reg.prev) & st_reg.ioc_en & ~st_reg.ansel;

  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PENABLE & ~PWRITE;
  assign wmask = PSTRB[0] ? 8'hff : 8'h00;

  always_comb begin
    case (PADDR)
      gpa_pkg::GPA_ADDR_LEVEL, gpa_pkg::GPA_ADDR_DIR, gpa_pkg::GPA_ADDR_ANSEL,
      gpa_pkg::GPA_ADDR_PULL, gpa_pkg::GPA_ADDR_OPT, gpa_pkg::GPA_ADDR_IOC,
      gpa_pkg::GPA_ADDR_IST, gpa_pkg::GPA_ADDR_IMSK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = PIN_IN;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = rd_level;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Sticky change flags; set beats clear
    st_next.ist = st_reg.ist | chg;
    // Setup cycle: prepare read data, answer in access phase
    if (PSEL & ~PENABLE) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~known;
      st_next.prdata = 32'h0000_0000;
      if (rd) begin
        case (PADDR)
          gpa_pkg::GPA_ADDR_LEVEL: st_next.prdata[7:0] = rd_level;
          gpa_pkg::GPA_ADDR_DIR:   st_next.prdata[7:0] = dir_eff
                                     & gpa_pkg::GPA_PIN_MASK;
          gpa_pkg::GPA_ADDR_ANSEL: st_next.prdata[7:0] = st_reg.ansel;
          gpa_pkg::GPA_ADDR_PULL:  st_next.prdata[7:0] = st_reg.pull_en;
          gpa_pkg::GPA_ADDR_OPT:   st_next.prdata[0] = st_reg.pu_dis;
          gpa_pkg::GPA_ADDR_IOC:   st_next.prdata[7:0] = st_reg.ioc_en;
          gpa_pkg::GPA_ADDR_IST:   st_next.prdata[7:0] = st_reg.ist;
          gpa_pkg::GPA_ADDR_IMSK:  st_next.prdata[7:0] = st_reg.imsk;
          default:                 st_next.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes take effect at the access edge
    if (wr & st_reg.pready) begin
      case (PADDR)
        gpa_pkg::GPA_ADDR_LEVEL:
          st_next.latch = (st_reg.latch & ~wmask)
                        | (PWDATA[7:0] & wmask & gpa_pkg::GPA_PIN_MASK);
        gpa_pkg::GPA_ADDR_DIR:
          st_next.dir = (st_reg.dir & ~wmask)
                      | (PWDATA[7:0] & wmask & gpa_pkg::GPA_DIR_WMASK);
        gpa_pkg::GPA_ADDR_ANSEL:
          st_next.ansel = (st_reg.ansel & ~wmask)
                        | (PWDATA[7:0] & wmask & gpa_pkg::GPA_ANSEL_MASK);
        gpa_pkg::GPA_ADDR_PULL:
          st_next.pull_en = (st_reg.pull_en & ~wmask)
                          | (PWDATA[7:0] & wmask & gpa_pkg::GPA_PULL_MASK);
        gpa_pkg::GPA_ADDR_OPT:
          if (PSTRB[0]) begin
            st_next.pu_dis = PWDATA[gpa_pkg::GPA_OPT_PU_DIS_BIT];
          end
        gpa_pkg::GPA_ADDR_IOC:
          st_next.ioc_en = (st_reg.ioc_en & ~wmask)
                         | (PWDATA[7:0] & wmask & gpa_pkg::GPA_IOC_MASK);
        gpa_pkg::GPA_ADDR_IST:
          st_next.ist = (st_reg.ist & ~(PWDATA[7:0] & wmask)) | chg;
        gpa_pkg::GPA_ADDR_IMSK:
          st_next.imsk = (st_reg.imsk & ~wmask) | (PWDATA[7:0] & wmask);
        default: st_next.ist = st_reg.ist | chg;
      endcase
    end
    st_next.irq = |(st_next.ist & st_next.imsk);
    // Pin drive: direction gates the driver, analog select does not
    st_next.pins.oe = ~dir_eff & gpa_pkg::GPA_PIN_MASK;
    st_next.pins.oe[gpa_pkg::GPA_OPEN_DRAIN_BIT] =
      ~dir_eff[gpa_pkg::GPA_OPEN_DRAIN_BIT] & ~drv_val[gpa_pkg::GPA_OPEN_DRAIN_BIT];
    st_next.pins.out = drv_val & gpa_pkg::GPA_PIN_MASK
                     & ~(8'h01 << gpa_pkg::GPA_OPEN_DRAIN_BIT);
    st_next.pins.pull = pull_w;
  end

  // State register with synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.dir <= gpa_pkg::GPA_DIR_RST;
      st_reg.ansel <= gpa_pkg::GPA_ANSEL_RST;
      st_reg.pull_en <= gpa_pkg::GPA_PULL_RST;
      st_reg.pu_dis <= gpa_pkg::GPA_PU_DIS_RST;
      st_reg.latch <= gpa_pkg::GPA_LATCH_RST;
      st_reg.ioc_en <= gpa_pkg::GPA_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign PIN_OUT = st_reg.pins.out;
  assign PIN_OE = st_reg.pins.oe;
  assign PIN_PULL = st_reg.pins.pull;
  assign IRQ = st_reg.irq;

  // Checks
  a_pin4_never_driven: assert property (@(posedge SYS_CLK) disable iff (RST)
    !PIN_OE[4] && !PIN_OUT[4]) else $error("pin 4 driven");
  a_input_dir_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_reg.dir[0] |=> !PIN_OE[0]) else $error("input pin driven");
  a_pin5_input_only: assert property (@(posedge SYS_CLK) disable iff (RST)
    !PIN_OE[5]) else $error("pin 5 driven");
  a_latch_write_rmw: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr && st_reg.pready && PADDR == gpa_pkg::GPA_ADDR_LEVEL && PSTRB[0]
    |=> st_reg.latch == ($past(PWDATA[7:0]) & gpa_pkg::GPA_PIN_MASK))
    else $error("latch not written");
  a_analog_reads_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    (rd_level & st_reg.ansel) == 8'h00) else $error("analog read nonzero");
  a_open_drain_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    PIN_OE[7] |-> !PIN_OUT[7]) else $error("pin 7 drives high");
  a_pullup_qualify: assert property (@(posedge SYS_CLK) disable iff (RST)
    (st_reg.pu_dis || st_reg.ansel[0]) |=> !PIN_PULL[0]) else $error("bad pullup");
  a_pin5_pull_fuse: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 PIN_PULL[5] == $past(FUSE_WORD[5])) else $error("pin 5 pull wrong");
  a_alt_priority: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.int2.en && !dir_eff[2] |=> PIN_OUT[2] == $past(ALT_OUT.int2.val))
    else $error("priority wrong");
  a_apb_answer: assert property (@(posedge SYS_CLK) disable iff (RST)
    PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("apb timing");
  c_latch_write: cover property (@(posedge SYS_CLK) wr && PREADY);
  c_change_irq: cover property (@(posedge SYS_CLK) $rose(IRQ));
  c_alt_scl: cover property (@(posedge SYS_CLK) ALT_OUT.scl7.en && PIN_OE[7]);
  c_analog_drive: cover property (@(posedge SYS_CLK) PIN_OE[0] && st_reg.ansel[0]);
  c_pin5_pull: cover property (@(posedge SYS_CLK) PIN_PULL[5] && !st_reg.pu_dis);

  // Reset values on the first cycle out of reset
  a_ansel_reset_one: assert property (@(posedge SYS_CLK)
    $fell(RST)
    |-> st_reg.ansel == gpa_pkg::GPA_ANSEL_RST)
    else $error("analog select reset wrong");

  a_ioc_reset_off: assert property (@(posedge SYS_CLK)
    $fell(RST)
    |-> st_reg.ioc_en == 8'h00)
    else $error("change enables not cleared");

  a_pudis_reset_set: assert property (@(posedge SYS_CLK)
    $fell(RST)
    |-> st_reg.pu_dis)
    else $error("global pull-up disable not set");

  a_dir_reset_input: assert property (@(posedge SYS_CLK)
    $fell(RST)
    |-> PIN_OE == 8'h00)
    else $error("driver on after reset");

  // Pull-up qualification
  a_pull_output_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    !dir_eff[1]
    |=> !PIN_PULL[1])
    else $error("pull-up on output pin");

  a_pull_alt_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.dbg0.en
    |=> !PIN_PULL[0])
    else $error("pull-up on alternate pin");

  a_pull_global_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_reg.pu_dis
    |=> (PIN_PULL & 8'hdf) == 8'h00)
    else $error("pull-up despite global disable");

  a_no_pull_high: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1
    |-> (PIN_PULL & 8'hd0) == 8'h00)
    else $error("pull-up on pin without one");

  // Analog select side effects
  a_analog_drive: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_reg.ansel[0] && !dir_eff[0]
    |=> PIN_OE[0])
    else $error("analog pin lost its driver");

  a_ioc_analog_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_reg.ansel[1]
    |-> !chg[1])
    else $error("change seen on analog pin");

  // Change status and interrupt level
  a_irq_level: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1
    |-> IRQ == |(st_reg.ist & st_reg.imsk))
    else $error("interrupt level wrong");

  a_status_sticky: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_reg.ist[0] && !(wr && PADDR == gpa_pkg::GPA_ADDR_IST)
    |=> st_reg.ist[0])
    else $error("status bit lost");

  a_change_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    chg[0]
    |=> st_reg.ist[0])
    else $error("change did not set status");

  // Register reads and writes
  a_pin5_dir_reads: assert property (@(posedge SYS_CLK) disable iff (RST)
    PSEL && !PENABLE && !PWRITE && PADDR == gpa_pkg::GPA_ADDR_DIR
    |=> PRDATA[5])
    else $error("pin 5 direction reads zero");

  a_level_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    PSEL && !PENABLE && !PWRITE && PADDR == gpa_pkg::GPA_ADDR_LEVEL
    |=> PRDATA[7:0] == $past(rd_level))
    else $error("level read wrong");

  a_pin4_read_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    PSEL && !PENABLE && !PWRITE && PADDR == gpa_pkg::GPA_ADDR_LEVEL
    |=> !PRDATA[4])
    else $error("pin 4 reads one");

  a_latch_read_stable: assert property (@(posedge SYS_CLK) disable iff (RST)
    PSEL && !PWRITE
    |=> $stable(st_reg.latch))
    else $error("read changed latch");

  a_dir_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr && st_reg.pready && PADDR == gpa_pkg::GPA_ADDR_DIR && PSTRB[0] && PWDATA[0]
    |=> st_reg.dir[0])
    else $error("direction write lost");

  // Output priority per pin
  a_dbg_priority: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.dbg0.en && !dir_eff[0]
    |=> PIN_OUT[0] == $past(ALT_OUT.dbg0.val))
    else $error("pin 0 source wrong");

  a_clko_priority: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.clko1.en && !dir_eff[1]
    |=> PIN_OUT[1] == $past(ALT_OUT.clko1.val))
    else $error("pin 1 source wrong");

  a_pgd_priority: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.pgd6.en && !dir_eff[6]
    |=> PIN_OUT[6] == $past(ALT_OUT.pgd6.val))
    else $error("pin 6 source wrong");

  a_scl_release: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALT_OUT.scl7.en && ALT_OUT.scl7.val
    |=> !PIN_OE[7])
    else $error("pin 7 not released");

endmodule

// File: test/gpa_board.sv
// Board model for the port A pads: device drive, board drive, pull-up.
// Assumes one clock; a pad nobody drives or pulls changes every cycle.
`timescale 1ns/1ps
module gpa_board (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pad
);
  logic [7:0] float_q = 8'h00;

  // Floating pattern
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Pad level, device drive first
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pad[i] = (i == 7) ? 1'b0 : pin_out[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pin_pull[i]) begin
        pad[i] = 1'b1;
      end else begin
        pad[i] = float_q[i];
      end
    end
  end
endmodule

// File: test/testbench.sv
// Self-checking bench for port A: APB master, pad model, expected state.
// Assumes the port answers every APB access within a few cycles.
`timescale 1ns/1ps
module testbench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         paddr = 8'h00;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               irq;
  logic [7:0]         pad;
  logic [7:0]         pin_out;
  logic [7:0]         pin_oe;
  logic [7:0]         pin_pull;
  logic [7:0]         ext_en = 8'hff;
  logic [7:0]         ext_val = 8'h00;
  logic [7:0]         ext_sel = 8'hff;
  logic [13:0]        fuse = 14'h0000;
  gpa_pkg::gpa_alts_s alt = '0;
  logic [31:0]        rdata;
  logic               rerr;
  logic [31:0]        seed = 32'd25414;
  logic [31:0]        r;
  logic [7:0]         m_dir = 8'hef;
  logic [7:0]         m_ans = 8'h0f;
  logic [7:0]         m_lat = 8'h00;
  logic [7:0]         m_pen = 8'h2f;
  logic               m_dis = 1'b1;
  int                 err_total = 0;
  int                 samples_checked = 0;

  always #12.5 clk = ~clk;

  gpa_port i_gpa_port (.SYS_CLK(clk), .RST(rst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pad),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULL(pin_pull),
    .FUSE_WORD(fuse), .ALT_OUT(alt), .IRQ(irq));

  gpa_board i_gpa_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull(pin_pull), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  // Random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Drive value per pin, highest enabled source last
  function automatic logic [7:0] e_val();
    logic [7:0] v;
    v = m_lat;
    if (alt.dbg0.en) v[0] = alt.dbg0.val;
    if (alt.clko1.en) v[1] = alt.clko1.val;
    if (alt.tmr2.en) v[2] = alt.tmr2.val;
    if (alt.int2.en) v[2] = alt.int2.val;
    if (alt.ccd6.en) v[6] = alt.ccd6.val;
    if (alt.pgd6.en) v[6] = alt.pgd6.val;
    if (alt.scl7.en) v[7] = alt.scl7.val;
    return v;
  endfunction

  // Driver enables: pins 4 and 5 never, pin 7 only when low
  function automatic logic [7:0] e_oe();
    logic [7:0] v;
    v = e_val();
    return ~m_dir & 8'hcf & {~v[7], 7'h7f};
  endfunction

  // Pull-ups: pins 3:0 by the rules, pin 5 by the fuse
  function automatic logic [7:0] e_pull();
    logic [3:0] a;
    a = {1'b0, alt.int2.en | alt.tmr2.en, alt.clko1.en, alt.dbg0.en};
    return {2'b00, fuse[5], 1'b0, m_pen[3:0] & m_dir[3:0] & ~m_ans[3:0] & ~a & {4{~m_dis}}};
  endfunction

  // Level read: pad value, analog pins and bit 4 zero
  function automatic logic [7:0] e_lvl();
    logic [7:0] o;
    o = e_oe();
    return ((o & e_val() & 8'h7f) | (~o & ext_en & ext_val) | (~o & ~ext_en & e_pull()))
      & ~m_ans & 8'hef;
  endfunction

  // Comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, {24'h0, exp}, "read");
  endtask

  // Load the model registers, then let the pads settle
  task automatic apply(input logic [7:0] dir_w);
    wr(gpa_pkg::GPA_ADDR_DIR, dir_w);
    wr(gpa_pkg::GPA_ADDR_ANSEL, m_ans);
    wr(gpa_pkg::GPA_ADDR_LEVEL, m_lat);
    wr(gpa_pkg::GPA_ADDR_PULL, m_pen);
    wr(gpa_pkg::GPA_ADDR_OPT, {7'h0, m_dis});
    ext_en <= ext_sel & ~e_oe();
    repeat (4) @(posedge clk);
  endtask

  task automatic pins_chk();
    chk(pin_oe, e_oe(), "oe");
    chk(pin_out & pin_oe, e_val() & e_oe() & 8'h7f, "out");
    chk(pin_pull, e_pull(), "pull");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(gpa_pkg::GPA_ADDR_DIR, 8'hef);
    rdc(gpa_pkg::GPA_ADDR_ANSEL, 8'h0f);
    rdc(gpa_pkg::GPA_ADDR_PULL, 8'h2f);
    rdc(gpa_pkg::GPA_ADDR_OPT, 8'h01);
    rdc(gpa_pkg::GPA_ADDR_IOC, 8'h00);
    rdc(gpa_pkg::GPA_ADDR_LEVEL, e_lvl());
    pins_chk();
    apb(1'b0, 8'h20, 32'h0);
    chk(rerr, 1, "unmapped err");
    chk(irq, 0, "irq");
    $display("test reset done");
    repeat (14) begin
      r = xs();
      alt <= r[17:0];
      ext_val <= xs();
      m_lat = xs();
      m_ans = xs() & 8'h0f;
      r = xs();
      m_dir = (r[7:0] & 8'hcf) | 8'h20;
      apply(r[7:0]);
      pins_chk();
      rdc(gpa_pkg::GPA_ADDR_DIR, m_dir);
      rdc(gpa_pkg::GPA_ADDR_LEVEL, e_lvl());
    end
    $display("test drive done");
    alt <= '0;
    fuse <= 14'h0020;
    ext_sel = 8'hc0;
    ext_val <= 8'h80;
    m_dir = 8'hff;
    m_ans = 8'h00;
    m_dis = 1'b0;
    for (int s = 0; s < 4; s++) begin
      if (s == 1) m_dir = 8'hfe;
      if (s == 2) m_ans = 8'h02;
      if (s == 3) begin
        m_dis = 1'b1;
        ext_sel = 8'hff;
      end
      apply(m_dir);
      pins_chk();
      rdc(gpa_pkg::GPA_ADDR_LEVEL, e_lvl());
    end
    $display("test pull done");
    ext_sel = 8'hff;
    ext_val <= 8'h00;
    m_dir = 8'hff;
    apply(m_dir);
    wr(gpa_pkg::GPA_ADDR_IOC, 8'hff);
    rdc(gpa_pkg::GPA_ADDR_IOC, 8'hf7);
    wr(gpa_pkg::GPA_ADDR_IOC, 8'h03);
    wr(gpa_pkg::GPA_ADDR_IST, 8'hff);
    wr(gpa_pkg::GPA_ADDR_IMSK, 8'h00);
    ext_val <= 8'h03;
    repeat (6) @(posedge clk);
    rdc(gpa_pkg::GPA_ADDR_IST, 8'h01);
    chk(irq, 0, "masked irq");
    wr(gpa_pkg::GPA_ADDR_IMSK, 8'h01);
    repeat (3) @(posedge clk);
    chk(irq, 1, "irq set");
    wr(gpa_pkg::GPA_ADDR_IST, 8'h01);
    repeat (3) @(posedge clk);
    rdc(gpa_pkg::GPA_ADDR_IST, 8'h00);
    chk(irq, 0, "irq clear");
    $display("test change done");
    stop_test();
  end
endmodule
